/* File: core/ftm_monitor.sv */
// One fan tachometer monitor channel: threshold, count and control.
// Assumes an 8-bit synchronous register port; tach pin is asynchronous.
`timescale 1ns/100ps
`default_nettype none
module ftm_monitor
  import ftm_pkg::*;
#(
  parameter int TICK_CYC = FTM_TICK_CYC
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  // Interrupt source register clear from the unit
  input wire logic irq_clear,
  // Tachometer pin
  input wire logic tach_input_pin,
  // Interrupt out
  output logic irq_n,
  output logic [7:0] irq_source_reg
);
  ftm_state_e state_q, state_d;
  logic [7:0] fan_overflow_threshold_q, fan_overflow_threshold_d;
  logic [7:0] fan_current_count_q, fan_current_count_d;
  logic [7:0] cnt_q, cnt_d;
  logic [7:0] ctrl_q, ctrl_d;
  logic [7:0] src_q, src_d;
  logic [7:0] rdata_q, rdata_d;
  logic pend_q, pend_d;
  logic half_q, half_d;
  logic sync1_q, sync2_q, prev_q;
  logic fan_monitor_enable, fan_irq_enable;
  logic [1:0] fan_divisor_select;
  logic tick, edge_seen, rev_done, over;
  logic [7:0] cnt_inc;

  assign fan_monitor_enable = ctrl_q[FTM_BIT_EN];
  assign fan_irq_enable = ctrl_q[FTM_BIT_IEN];
  assign fan_divisor_select = ctrl_q[1:0];

  // Two-stage synchroniser, then rising edge detect on the second stage
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      prev_q <= 1'b0;
    end
    else
    begin
      sync1_q <= tach_input_pin;
      sync2_q <= sync1_q;
      prev_q <= sync2_q;
    end
  end
  assign edge_seen = sync2_q && !prev_q;

  ftm_tick_div #(
    .TICK_CYC(TICK_CYC)
  ) u_div (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .run(fan_monitor_enable && state_q != FTM_IDLE),
    .fan_divisor_select(fan_divisor_select),
    .tick(tick)
  );

  // Two tach pulses make one revolution
  assign rev_done = edge_seen && half_q;
  // Counter plus this cycle's tick, held at all ones so a stall cannot wrap
  assign cnt_inc = (tick && cnt_q != FTM_COUNT_MAX) ? cnt_q + 8'h01 : cnt_q;
  // Strictly above threshold; taken from the counter, not the next-state
  // logic, so the compare never loops back through the publish path
  assign over = (cnt_inc > fan_overflow_threshold_q);

  // Measurement, count publication, interrupt and register next values
  always_comb
  begin
    state_d = state_q;
    cnt_d = cnt_q;
    half_d = half_q;
    fan_current_count_d = fan_current_count_q;
    pend_d = pend_q;
    src_d = src_q;
    ctrl_d = ctrl_q;
    fan_overflow_threshold_d = fan_overflow_threshold_q;
    rdata_d = rdata_q;
    cnt_d = cnt_inc;
    unique case (state_q)
      FTM_IDLE:
      begin
        cnt_d = 8'h00;
        half_d = 1'b0;
        if (fan_monitor_enable)
          state_d = FTM_ARM;
      end
      FTM_ARM:
      begin
        // Wait for a first edge so the first interval is a whole revolution
        cnt_d = 8'h00;
        if (edge_seen)
          state_d = FTM_MEAS;
      end
      FTM_MEAS:
      begin
        if (edge_seen)
          half_d = !half_q;
        if (rev_done)
        begin
          fan_current_count_d = cnt_d;
          cnt_d = 8'h00;
          if (fan_irq_enable && over)
          begin
            pend_d = 1'b1;
            src_d = FTM_CTRL_OFS;
            state_d = FTM_HOLD;
          end
        end
        else if (cnt_d == FTM_COUNT_MAX)
          fan_current_count_d = FTM_COUNT_MAX;
      end
      FTM_HOLD:
      begin
        cnt_d = 8'h00;
        if (!pend_q)
          state_d = FTM_ARM;
      end
    endcase
    // Clearing the interrupt also zeroes the published count
    if (irq_clear && pend_q && !(pend_d && !pend_q))
    begin
      pend_d = 1'b0;
      src_d = 8'h00;
      fan_current_count_d = FTM_COUNT_RST;
      state_d = FTM_ARM;
      cnt_d = 8'h00;
      half_d = 1'b0;
    end
    if (reg_wr && reg_addr == FTM_CTRL_OFS)
      ctrl_d = reg_wdata;
    if (reg_wr && reg_addr == FTM_THRESH_OFS)
      fan_overflow_threshold_d = reg_wdata;
    if (!fan_monitor_enable)
    begin
      state_d = FTM_IDLE;
      fan_current_count_d = FTM_COUNT_RST;
    end
    if (reg_rd)
    begin
      unique case (reg_addr)
        FTM_CTRL_OFS: rdata_d = ctrl_q & 8'hc3;
        FTM_THRESH_OFS: rdata_d = fan_overflow_threshold_q;
        FTM_COUNT_OFS: rdata_d = fan_current_count_q;
        default: rdata_d = 8'h00;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state_q <= FTM_IDLE;
      cnt_q <= 8'h00;
      half_q <= 1'b0;
      fan_current_count_q <= FTM_COUNT_RST;
      fan_overflow_threshold_q <= FTM_THRESH_RST;
      ctrl_q <= FTM_CTRL_RST;
      pend_q <= 1'b0;
      src_q <= 8'h00;
      rdata_q <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      half_q <= half_d;
      fan_current_count_q <= fan_current_count_d;
      fan_overflow_threshold_q <= fan_overflow_threshold_d;
      ctrl_q <= ctrl_d;
      pend_q <= pend_d;
      src_q <= src_d;
      rdata_q <= rdata_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign irq_n = !pend_q;
  assign irq_source_reg = src_q;

  chk_count_frozen: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == FTM_HOLD && !irq_clear && fan_monitor_enable |=>
    $stable(fan_current_count_q))
    else $error("count changed while interrupt pending");
  chk_clear_zeroes: assert property (@(posedge core_clk) disable iff (!rst_n)
    pend_q && irq_clear |=> fan_current_count_q == 8'h00 && irq_n)
    else $error("clear did not zero count");
  chk_disabled_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    !fan_monitor_enable |=> fan_current_count_q == 8'h00)
    else $error("count nonzero while disabled");
  chk_irq_source: assert property (@(posedge core_clk) disable iff (!rst_n)
    !irq_n |-> irq_source_reg == FTM_CTRL_OFS)
    else $error("source register wrong while interrupt asserted");
  chk_irq_cause: assert property (@(posedge core_clk) disable iff (!rst_n)
    $fell(irq_n) |-> fan_current_count_q > fan_overflow_threshold_q && fan_irq_enable)
    else $error("interrupt without threshold cause");
  chk_count_sat: assert property (@(posedge core_clk) disable iff (!rst_n)
    cnt_q == FTM_COUNT_MAX && tick && state_q == FTM_MEAS && !rev_done |=> cnt_q == FTM_COUNT_MAX)
    else $error("counter wrapped");
  chk_polled_free: assert property (@(posedge core_clk) disable iff (!rst_n)
    !fan_irq_enable |-> irq_n)
    else $error("interrupt in polled mode");
  chk_no_arm_irq: assert property (@(posedge core_clk) disable iff (!rst_n)
    state_q == FTM_ARM && !pend_q |=> irq_n)
    else $error("interrupt from invalid count");
endmodule : ftm_monitor
`default_nettype wire

/* File: core/ftm_pkg.sv */
// Package for the fan tachometer count monitor channel.
// Assumes an 8-bit register port with byte addresses as printed.
package ftm_pkg;
  localparam logic [7:0] FTM_CTRL_OFS = 8'h30;
  localparam logic [7:0] FTM_THRESH_OFS = 8'h31;
  localparam logic [7:0] FTM_COUNT_OFS = 8'h32;
  localparam logic [7:0] FTM_THRESH_RST = 8'h00;
  localparam logic [7:0] FTM_COUNT_RST = 8'h00;
  localparam logic [7:0] FTM_CTRL_RST = 8'h00;
  localparam logic [7:0] FTM_COUNT_MAX = 8'hff;
  localparam int FTM_BIT_EN = 7;
  localparam int FTM_BIT_IEN = 6;
  localparam int FTM_CORE_HZ = 250_000_000;
  localparam int FTM_TICK_HZ = 20_000;
  localparam int FTM_TICK_CYC = FTM_CORE_HZ / FTM_TICK_HZ;
  localparam int FTM_PULSES_PER_REV = 2;
  typedef enum logic [1:0] {FTM_IDLE, FTM_ARM, FTM_MEAS, FTM_HOLD} ftm_state_e;
endpackage : ftm_pkg

/* File: core/ftm_tick_div.sv */
// Tick divider: 20 kHz base enable, then scaled by 1/2/4/8.
// Assumes a single core clock and synchronous reset.
`timescale 1ns/100ps
`default_nettype none
module ftm_tick_div
  import ftm_pkg::*;
#(
  parameter int TICK_CYC = FTM_TICK_CYC
)
(
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Control
  input wire logic run,
  input wire logic [1:0] fan_divisor_select,
  // Scaled enable
  output logic tick
);
  logic [15:0] base_q, base_d;
  logic [2:0] pre_q, pre_d;
  logic base_hit;
  logic [2:0] pre_mask;

  // Base counter and prescaler next values
  always_comb
  begin
    base_hit = (base_q == 16'(TICK_CYC - 1));
    pre_mask = 3'((4'h1 << fan_divisor_select) - 4'h1);
    base_d = base_hit ? 16'h0000 : base_q + 16'h0001;
    pre_d = pre_q;
    if (base_hit)
      pre_d = ((pre_q & pre_mask) == pre_mask) ? 3'h0 : pre_q + 3'h1;
    if (!run)
    begin
      base_d = 16'h0000;
      pre_d = 3'h0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      base_q <= 16'h0000;
      pre_q <= 3'h0;
    end
    else
    begin
      base_q <= base_d;
      pre_q <= pre_d;
    end
  end

  // Divide by 2^select: tick when low bits of prescaler all set
  assign tick = run && base_hit && ((pre_q & pre_mask) == pre_mask);
endmodule : ftm_tick_div
`default_nettype wire

/* File: tb/ftm_fan_model.sv */
// Behavioural fan: tach output toggles every half_cyc core periods.
// Assumes a 4 ns core period; stopped fan holds the pin low.
`timescale 1ns/100ps
`default_nettype none
module ftm_fan_model
(
  // Control from the bench
  input wire logic run,
  input wire logic [15:0] half_cyc,
  // Tach pin
  output logic tach_input_pin
);
  // Two rising edges per revolution, unrelated to the core clock phase
  initial
  begin
    tach_input_pin = 1'b0;
    #1.3;
    forever
    begin
      if (run)
      begin
        #(half_cyc * 4);
        tach_input_pin = ~tach_input_pin;
      end
      else
      begin
        tach_input_pin = 1'b0; // Stopping never makes a rising edge
        #4;
      end
    end
  end
endmodule : ftm_fan_model
`default_nettype wire

/* File: tb/fan_tach_count_monitor_tb.sv */
// Testbench for the fan tach monitor: register tasks and a fan model.
// Assumes TICK_CYC shortened to 4, so count = half_cyc / divisor.
`timescale 1ns/100ps
`default_nettype none
module fan_tach_count_monitor_tb;
  import ftm_pkg::*;
  logic core_clk, rst_n, reg_wr, reg_rd, irq_clear, tach, irq_n, run;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, irq_src, rd;
  logic [15:0] half_cyc;
  int n_fail, samples_checked;
  ftm_monitor #(.TICK_CYC(4)) u_ftm_monitor (.core_clk(core_clk), .rst_n(rst_n),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .irq_clear(irq_clear), .tach_input_pin(tach), .irq_n(irq_n),
    .irq_source_reg(irq_src));
  ftm_fan_model u_ftm_fan_model (.run(run), .half_cyc(half_cyc), .tach_input_pin(tach));
  // 250 MHz core clock
  initial
  begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  task automatic finish_test();
    if (n_fail == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : finish_test
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask : cyc
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    cyc(1);
    reg_wr = 1'b0;
    cyc(1);
  endtask : wr
  // Read data lands at the taking edge
  task automatic rdr(input logic [7:0] a);
    reg_rd = 1'b1;
    reg_addr = a;
    cyc(1);
    reg_rd = 1'b0;
    rd = reg_rdata;
    cyc(1);
  endtask : rdr
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk8
  // Tach phase against the tick leaves one count of slack
  task automatic chk_near(input logic [7:0] got, input int exp);
    samples_checked++;
    if ($isunknown(got) || int'(got) < exp - 1 || int'(got) > exp + 1)
    begin
      n_fail++;
      $display("unexpected at %0t: count %h near %0d", $time, got, exp);
    end
  endtask : chk_near
  // Watchdog: whole run needs at most about 8k cycles
  initial
  begin
    #200us;
    n_fail++;
    finish_test();
  end
  initial
  begin
    rst_n = 1'b0; reg_wr = 1'b0; reg_rd = 1'b0; irq_clear = 1'b0;
    reg_addr = 8'h00; reg_wdata = 8'h00; run = 1'b1; half_cyc = 16'd40;
    cyc(10);
    rst_n = 1'b1;
    chk8({7'h00, irq_n}, 8'h01);
    rdr(FTM_THRESH_OFS); chk8(rd, FTM_THRESH_RST);
    rdr(FTM_COUNT_OFS); chk8(rd, FTM_COUNT_RST);
    rdr(8'h40); chk8(rd, 8'h00);
    wr(FTM_THRESH_OFS, 8'ha5); rdr(FTM_THRESH_OFS); chk8(rd, 8'ha5);
    wr(FTM_COUNT_OFS, 8'h55); rdr(FTM_COUNT_OFS); chk8(rd, 8'h00);
    wr(FTM_THRESH_OFS, 8'h01);
    // Polled mode over all divisor codes; low threshold must not interrupt
    for (int c = 0; c < 4; c++)
    begin
      wr(FTM_CTRL_OFS, 8'h80 | 8'(c));
      rdr(FTM_CTRL_OFS); chk8(rd, 8'h80 | 8'(c));
      rdr(FTM_COUNT_OFS); chk8(rd, 8'h00);
      cyc(500);
      rdr(FTM_COUNT_OFS); chk_near(rd, 40 >> c);
      chk8({7'h00, irq_n}, 8'h01);
      wr(FTM_CTRL_OFS, 8'h00);
    end
    // Polled refresh after a speed change, then stall to saturation
    wr(FTM_CTRL_OFS, 8'h80); cyc(500); half_cyc = 16'd60; cyc(800);
    rdr(FTM_COUNT_OFS); chk_near(rd, 60);
    run = 1'b0; cyc(1300);
    rdr(FTM_COUNT_OFS); chk8(rd, FTM_COUNT_MAX);
    run = 1'b1; half_cyc = 16'd40; wr(FTM_CTRL_OFS, 8'h00);
    // Count 40 stays under threshold 48
    wr(FTM_THRESH_OFS, 8'h30); wr(FTM_CTRL_OFS, 8'hc0); cyc(800);
    chk8({7'h00, irq_n}, 8'h01);
    wr(FTM_CTRL_OFS, 8'h00); wr(FTM_THRESH_OFS, 8'h20); wr(FTM_CTRL_OFS, 8'hc0);
    for (int k = 0; k < 1000 && irq_n !== 1'b0; k++) cyc(1);
    chk8({7'h00, irq_n}, 8'h00);
    chk8(irq_src, FTM_CTRL_OFS);
    rdr(FTM_COUNT_OFS); chk_near(rd, 40);
    half_cyc = 16'd60; cyc(800);
    rdr(FTM_COUNT_OFS); chk_near(rd, 40);
    irq_clear = 1'b1; cyc(1); irq_clear = 1'b0; cyc(1);
    chk8({7'h00, irq_n}, 8'h01);
    chk8(irq_src, 8'h00);
    rdr(FTM_COUNT_OFS); chk8(rd, 8'h00);
    cyc(800);
    rdr(FTM_COUNT_OFS); chk_near(rd, 60);
    finish_test();
  end
endmodule : fan_tach_count_monitor_tb
`default_nettype wire
